// ==== hdl/rx_pack_consts.svh ====
// Bit positions, mode codes, register offsets and reset values of the receive status bus packer.
`ifndef RX_PACK_CONSTS_SVH
`define RX_PACK_CONSTS_SVH
`define BUS_W 16
`define BUS_MSB 15
`define BYTE_MSB 7
`define CODE_MSB 9
`define POS_CTRL 8
`define POS_ERR 9
`define POS_SYNC 10
`define POS_DISP 11
`define POS_PAT 12
`define POS_DEL 13
`define POS_INS 14
`define POS_RDISP 15
`define MODE_W 2
`define MODE_8B10B 2'h0
`define MODE_PIPE 2'h1
`define MODE_SONET 2'h2
`define MODE_TEN 2'h3
`define OFS_CTRL 4'h0
`define OFS_STAT 4'h4
`define OFS_MASK 4'h8
`define OFS_LAST 4'hC
`define EV_W 4
`define EV_ERR 0
`define EV_DISP 1
`define EV_DEL 2
`define EV_INS 3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ZERO16 16'h0000
`define ZERO32 32'h0000_0000
`endif

// ==== hdl/rx_pack_pkg.sv ====
// Types shared by the receive status bus packer.
package rx_pack_pkg;
  typedef logic [1:0] rx_mode_t;
  typedef logic [1:0] pipe_status_t;
  typedef logic [15:0] packed_bus_t;
endpackage

// ==== hdl/rx_word_if.sv ====
// Interface carrying one received word and its status from top to packing core.
`timescale 1ns/10ps
`default_nettype none
interface rx_word_if;
  logic [9:0] code;
  logic ctrl;
  logic err;
  logic sync;
  logic disp_err;
  logic pat;
  logic del;
  logic ins;
  logic [1:0] pipe_status;
  logic run_disp;
  logic size_ind;
  logic [1:0] mode;
  logic [15:0] bus;
  modport src (output code, ctrl, err, sync, disp_err, pat, del, ins, pipe_status, run_disp, size_ind, mode,
    input bus);
  modport core (input code, ctrl, err, sync, disp_err, pat, del, ins, pipe_status, run_disp, size_ind, mode,
    output bus);
endinterface
`default_nettype wire

// ==== hdl/rx_pack_core.sv ====
// Combinational packing of one received word into the wide receive bus.
`timescale 1ns/10ps
`default_nettype none
`include "rx_pack_consts.svh"
module rx_pack_core
(
  rx_word_if.core w
);
  import rx_pack_pkg::*;

  always_comb
  begin
    w.bus = `ZERO16;
    unique case (w.mode)
      `MODE_8B10B, `MODE_PIPE:
      begin
        w.bus[`BYTE_MSB:0] = w.code[`BYTE_MSB:0];
        w.bus[`POS_CTRL] = w.ctrl;
        w.bus[`POS_ERR] = w.err;
        w.bus[`POS_SYNC] = w.sync;
        w.bus[`POS_DISP] = w.disp_err;
        w.bus[`POS_PAT] = w.pat;
        if (w.mode == `MODE_PIPE)
        begin
          w.bus[`POS_INS:`POS_DEL] = w.pipe_status;
        end
        else
        begin
          w.bus[`POS_DEL] = w.del;
          w.bus[`POS_INS] = w.ins;
        end
        w.bus[`POS_RDISP] = w.run_disp;
      end
      `MODE_SONET:
      begin
        // Bit 11 is reserved here and stays zero.
        w.bus[`BYTE_MSB:0] = w.code[`BYTE_MSB:0];
        w.bus[`POS_CTRL] = w.size_ind;
        w.bus[`POS_SYNC] = w.sync;
        w.bus[`POS_PAT] = w.pat;
      end
      `MODE_TEN:
      begin
        w.bus[`CODE_MSB:0] = w.code;
        w.bus[`POS_SYNC] = w.sync;
        w.bus[`POS_DISP] = w.disp_err;
        w.bus[`POS_PAT] = w.pat;
        w.bus[`POS_DEL] = w.del;
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== hdl/rx_status_bus_packer.sv ====
// Top of the receive status bus packer with its AXI4-Lite register slave.
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "rx_pack_consts.svh"
module rx_status_bus_packer
(
  // Clock, reset and enable.
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Receive word and status from the PCS.
  input wire logic [9:0] rx_code,
  input wire logic rx_ctrl,
  input wire logic rx_err,
  input wire logic rx_sync,
  input wire logic rx_disp_err,
  input wire logic rx_pat,
  input wire logic rx_del,
  input wire logic rx_ins,
  input wire rx_pack_pkg::pipe_status_t rx_pipe_status,
  input wire logic rx_run_disp,
  input wire logic framing_size_indication,
  // Packed bus toward the fabric.
  output logic [15:0] rx_bus,
  // Interrupt.
  output logic irq,
  // AXI4-Lite slave.
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import rx_pack_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [15:0] bus;
    rx_mode_t mode;
    logic [3:0] stat;
    logic [3:0] mask;
    logic irq;
    logic aw_got;
    logic [3:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [3:0] ev;
  logic [3:0] wclr;
  logic do_wr;

  rx_word_if w ();

  assign w.code = rx_code;
  assign w.ctrl = rx_ctrl;
  assign w.err = rx_err;
  assign w.sync = rx_sync;
  assign w.disp_err = rx_disp_err;
  assign w.pat = rx_pat;
  assign w.del = rx_del;
  assign w.ins = rx_ins;
  assign w.pipe_status = rx_pipe_status;
  assign w.run_disp = rx_run_disp;
  assign w.size_ind = framing_size_indication;
  assign w.mode = state_reg.mode;

  rx_pack_core u_core (.w(w));

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    state_next = state_reg;
    ev = '0;
    wclr = '0;
    do_wr = 1'b0;
    // Events only count where the current mode defines them on the bus.
    ev[`EV_ERR] = rx_err && (state_reg.mode == `MODE_8B10B || state_reg.mode == `MODE_PIPE);
    ev[`EV_DISP] = rx_disp_err && (state_reg.mode != `MODE_SONET);
    ev[`EV_DEL] = rx_del && (state_reg.mode == `MODE_8B10B || state_reg.mode == `MODE_TEN);
    ev[`EV_INS] = rx_ins && (state_reg.mode == `MODE_8B10B);
    state_next.bus = w.bus;

    if (s_axi_awvalid && state_reg.awready)
    begin
      state_next.aw_got = 1'b1;
      state_next.aw_addr = s_axi_awaddr;
      state_next.awready = 1'b0;
    end
    if (s_axi_wvalid && state_reg.wready)
    begin
      state_next.w_got = 1'b1;
      state_next.w_data = s_axi_wdata;
      state_next.w_strb = s_axi_wstrb;
      state_next.wready = 1'b0;
    end
    if (state_reg.aw_got && state_reg.w_got && !state_reg.bvalid)
    begin
      do_wr = 1'b1;
      state_next.aw_got = 1'b0;
      state_next.w_got = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = `RESP_OKAY;
      unique case (state_reg.aw_addr)
        `OFS_CTRL:
        begin
          if (state_reg.w_strb[0])
          begin
            state_next.mode = state_reg.w_data[`MODE_W-1:0];
          end
        end
        `OFS_STAT:
        begin
          if (state_reg.w_strb[0])
          begin
            wclr = state_reg.w_data[`EV_W-1:0];
          end
        end
        `OFS_MASK:
        begin
          if (state_reg.w_strb[0])
          begin
            state_next.mask = state_reg.w_data[`EV_W-1:0];
          end
        end
        default:
        begin
          state_next.bresp = `RESP_SLVERR;
        end
      endcase
    end
    if (state_reg.bvalid && s_axi_bready)
    begin
      state_next.bvalid = 1'b0;
      state_next.awready = 1'b1;
      state_next.wready = 1'b1;
    end

    // An event in the clearing cycle wins over the clear.
    state_next.stat = (state_reg.stat & ~wclr) | ev;
    state_next.irq = |(state_next.stat & state_next.mask);

    if (s_axi_arvalid && state_reg.arready)
    begin
      state_next.arready = 1'b0;
      state_next.rvalid = 1'b1;
      state_next.rresp = `RESP_OKAY;
      state_next.rdata = `ZERO32;
      unique case (s_axi_araddr)
        `OFS_CTRL: state_next.rdata[`MODE_W-1:0] = state_reg.mode;
        `OFS_STAT: state_next.rdata[`EV_W-1:0] = state_reg.stat;
        `OFS_MASK: state_next.rdata[`EV_W-1:0] = state_reg.mask;
        `OFS_LAST: state_next.rdata[`BUS_MSB:0] = state_reg.bus;
        default: state_next.rresp = `RESP_SLVERR;
      endcase
    end
    if (state_reg.rvalid && s_axi_rready)
    begin
      state_next.rvalid = 1'b0;
      state_next.arready = 1'b1;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state_reg <= '0;
      state_reg.awready <= 1'b1;
      state_reg.wready <= 1'b1;
      state_reg.arready <= 1'b1;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
    end
  end

  assign rx_bus = state_reg.bus;
  assign irq = state_reg.irq;
  assign s_axi_awready = state_reg.awready;
  assign s_axi_wready = state_reg.wready;
  assign s_axi_bvalid = state_reg.bvalid;
  assign s_axi_bresp = state_reg.bresp;
  assign s_axi_arready = state_reg.arready;
  assign s_axi_rvalid = state_reg.rvalid;
  assign s_axi_rdata = state_reg.rdata;
  assign s_axi_rresp = state_reg.rresp;

  // ****************************************
  // Checks
  // ****************************************
  a_byte_data: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(state_reg.mode) == `MODE_8B10B) |-> rx_bus[7:0] == $past(rx_code[7:0]))
    else $error("byte lane does not follow code");
  a_ctrl_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(state_reg.mode) == `MODE_8B10B) |-> rx_bus[8] == $past(rx_ctrl))
    else $error("control flag misplaced");
  a_err_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(state_reg.mode) == `MODE_PIPE) |-> rx_bus[9] == $past(rx_err))
    else $error("code violation flag misplaced");
  a_sync_disp: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(state_reg.mode) == `MODE_8B10B) |-> rx_bus[11:10] == $past({rx_disp_err, rx_sync}))
    else $error("sync or disparity flag misplaced");
  a_pat_bit: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(state_reg.mode) != `MODE_SONET) |-> rx_bus[12] == $past(rx_pat))
    else $error("pattern flag misplaced");
  a_rm_bits: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(state_reg.mode) == `MODE_8B10B) |-> rx_bus[14:13] == $past({rx_ins, rx_del}))
    else $error("rate match flags misplaced");
  a_pipe_stat: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(state_reg.mode) == `MODE_PIPE) |-> rx_bus[14:13] == $past(rx_pipe_status))
    else $error("pipe status misplaced");
  a_run_disp: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(state_reg.mode) == `MODE_PIPE) |-> rx_bus[15] == $past(rx_run_disp))
    else $error("running disparity misplaced");
  a_sonet_map: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(state_reg.mode) == `MODE_SONET)
    |-> rx_bus[8] == $past(framing_size_indication) && rx_bus[11] == 1'b0 && rx_bus[15:13] == 3'h0)
    else $error("sonet layout wrong");
  a_ten_map: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(state_reg.mode) == `MODE_TEN)
    |-> rx_bus[9:0] == $past(rx_code) && rx_bus[13] == $past(rx_del) && rx_bus[15:14] == 2'h0)
    else $error("ten bit layout wrong");
  a_irq_level: assert property (@(posedge sys_clk) disable iff (!reset_n)
    irq == |(state_reg.stat & state_reg.mask))
    else $error("interrupt out of step with status");
  a_err_byte: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(state_reg.mode) == `MODE_8B10B) |-> rx_bus[`POS_ERR] == $past(rx_err))
    else $error("code violation flag misplaced in byte mode");
  a_disp_run: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(state_reg.mode) == `MODE_8B10B) |-> rx_bus[`POS_RDISP] == $past(rx_run_disp))
    else $error("running disparity misplaced in byte mode");
  a_pipe_low: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(state_reg.mode) == `MODE_PIPE)
    |-> rx_bus[`POS_PAT:0] == $past({rx_pat, rx_disp_err, rx_sync, rx_err, rx_ctrl, rx_code[`BYTE_MSB:0]}))
    else $error("pipe mode low flags misplaced");
  a_sonet_byte: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(state_reg.mode) == `MODE_SONET) |-> rx_bus[`BYTE_MSB:0] == $past(rx_code[`BYTE_MSB:0]))
    else $error("sonet byte misplaced");
  a_sonet_flags: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(state_reg.mode) == `MODE_SONET)
    |-> rx_bus[`POS_SYNC] == $past(rx_sync) && rx_bus[`POS_PAT] == $past(rx_pat) && rx_bus[`POS_ERR] == 1'b0)
    else $error("sonet flags misplaced");
  a_ten_flags: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(state_reg.mode) == `MODE_TEN) |-> rx_bus[`POS_PAT:`POS_SYNC] == $past({rx_pat, rx_disp_err, rx_sync}))
    else $error("ten bit flags misplaced");
  a_sync_any: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(reset_n)) |-> rx_bus[`POS_SYNC] == $past(rx_sync))
    else $error("sync status misplaced");

  // ****************************************
  // Register slave checks
  // ****************************************
  a_reset_idle: assert property (@(posedge sys_clk)
    !reset_n |=> rx_bus == `ZERO16 && !irq && !s_axi_bvalid && !s_axi_rvalid && s_axi_awready && s_axi_arready)
    else $error("state not cleared by reset");
  // A frozen slave must not drop a pending answer, or the master would miss it.
  a_freeze: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(reset_n) && !$past(clk_en))
    |-> $stable(rx_bus) && $stable(irq) && $stable(s_axi_bvalid) && $stable(s_axi_rvalid))
    else $error("state moved while enable low");
  a_bvalid_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rvalid_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");
  a_wr_once: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(s_axi_bvalid && s_axi_bready)) |-> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write response not closed");
  a_rd_once: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(s_axi_rvalid && s_axi_rready)) |-> !s_axi_rvalid && s_axi_arready)
    else $error("read response not closed");
  a_ar_taken: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(reset_n) && $past(clk_en) && $past(s_axi_arvalid && s_axi_arready)) |-> s_axi_rvalid && !s_axi_arready)
    else $error("read address not answered");

  // ****************************************
  // Status checks
  // ****************************************
  a_err_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(rx_err) && $past(state_reg.mode) == `MODE_8B10B) |-> state_reg.stat[`EV_ERR])
    else $error("code violation not recorded");
  a_disp_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(rx_disp_err) && $past(state_reg.mode) != `MODE_SONET) |-> state_reg.stat[`EV_DISP])
    else $error("disparity error not recorded");
  a_ins_sticky: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(clk_en) && $past(rx_ins) && $past(state_reg.mode) == `MODE_8B10B) |-> state_reg.stat[`EV_INS])
    else $error("insertion not recorded");
  a_stat_hold: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($past(reset_n) && !$past(do_wr)) |-> (state_reg.stat & $past(state_reg.stat)) == $past(state_reg.stat))
    else $error("status bit lost without a write");
  a_irq_masked: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state_reg.mask == '0 |-> !irq)
    else $error("interrupt while fully masked");
endmodule
`default_nettype wire

// ==== dv/rx_fabric_model.sv ====
// Model of the fabric logic that takes each packed receive word.
`timescale 1ns/10ps
`default_nettype none
module rx_fabric_model
(
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Packed bus and the mode the fabric expects.
  input wire logic [15:0] rx_bus,
  input wire logic [1:0] mode,
  // Last word taken, reserved bits dropped.
  output logic [15:0] word_reg
);
  logic [15:0] keep;
  // Reserved positions are never trusted, so a stray one cannot leak into user logic.
  always_comb keep = (mode == 2'h2) ? 16'h15FF : (mode == 2'h3) ? 16'h3FFF : 16'hFFFF;
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      word_reg <= 16'h0000;
    else
      word_reg <= rx_bus & keep;
  end
endmodule
`default_nettype wire

// ==== dv/tb_rx_status_bus_packer.sv ====
// Self-checking bench for the receive status bus packer.
`timescale 1ns/10ps
`default_nettype none
`include "rx_pack_consts.svh"
module tb_rx_status_bus_packer;
  logic sys_clk = 0, reset_n = 0, clk_en = 1, irq;
  logic [20:0] stim = 0;
  wire logic [9:0] rx_code = stim[9:0];
  wire logic rx_ctrl = stim[10], rx_err = stim[11], rx_sync = stim[12], rx_disp_err = stim[13];
  wire logic rx_pat = stim[14], rx_del = stim[15], rx_ins = stim[16], rx_run_disp = stim[19];
  wire logic [1:0] rx_pipe_status = stim[18:17];
  wire logic framing_size_indication = stim[20];
  logic [15:0] rx_bus, fab_word;
  logic [3:0] s_axi_awaddr = 0, s_axi_wstrb = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r, md = 0;
  integer miscompares = 0, checks = 0, seed = 1;
  int ev_pos[4] = '{11, 13, 15, 16};
  rx_status_bus_packer u_rx_status_bus_packer (.*);
  rx_fabric_model u_rx_fabric_model (.sys_clk(sys_clk), .reset_n(reset_n), .rx_bus(rx_bus), .mode(md),
    .word_reg(fab_word));
  initial
  begin
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid && n < 50);
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid && n < 50);
    v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask
  task automatic wait_irq();
    int n;
    for (n = 0; n < 10 && irq !== 1'b1; n++) @(posedge sys_clk);
    #1;
  endtask
  function automatic logic [15:0] exp_bus(input logic [1:0] m, input logic [20:0] v);
    case (m)
      `MODE_8B10B: exp_bus = {v[19], v[16:10], v[7:0]};
      `MODE_PIPE: exp_bus = {v[19], v[18:17], v[14:10], v[7:0]};
      `MODE_SONET: exp_bus = {3'b000, v[14], 1'b0, v[12], 1'b0, v[20], v[7:0]};
      default: exp_bus = {2'b00, v[15:12], v[9:0]};
    endcase
  endfunction
  // Watchdog sized well above the several hundred cycles the tests need.
  initial
  begin
    #(25 * 20000);
    miscompares++;
    summarize();
  end
  initial
  begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1;
    axi_rd(`OFS_CTRL, d, r);
    chk(d, `ZERO32);
    axi_rd(`OFS_MASK, d, r);
    chk(d, `ZERO32);
    for (int m = 0; m < 4; m++)
    begin
      md = m[1:0];
      axi_wr(`OFS_CTRL, {30'h0, md}, r);
      chk(r, `RESP_OKAY);
      for (int k = 0; k < 40; k++)
      begin
        @(posedge sys_clk);
        stim <= (k == 0) ? 21'h1F_FFFF : (k == 1) ? 21'h0 : 21'($random(seed));
        @(posedge sys_clk);
        #1;
        chk(rx_bus, exp_bus(md, stim));
        @(posedge sys_clk);
        #1;
        chk(fab_word, exp_bus(md, stim));
      end
      axi_rd(`OFS_LAST, d, r);
      chk(d, {16'h0, exp_bus(md, stim)});
      $display("mode %0d packing test done", m);
    end
    @(posedge sys_clk);
    stim <= 21'h0_0155;
    @(posedge sys_clk);
    clk_en <= 0;
    stim <= 21'h1F_FFFF;
    repeat (3) @(posedge sys_clk);
    #1;
    chk(rx_bus, exp_bus(md, 21'h0_0155));
    @(posedge sys_clk);
    clk_en <= 1;
    @(posedge sys_clk);
    #1;
    chk(rx_bus, exp_bus(md, stim));
    $display("clock enable test done");
    axi_rd(4'h1, d, r);
    chk(r, `RESP_SLVERR);
    chk(d, `ZERO32);
    axi_wr(`OFS_LAST, 32'h1, r);
    chk(r, `RESP_SLVERR);
    md = 0;
    axi_wr(`OFS_CTRL, 32'h0, r);
    stim <= 0;
    axi_wr(`OFS_STAT, 32'hF, r);
    axi_wr(`OFS_MASK, 32'hF, r);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge sys_clk);
      stim <= 21'h1 << ev_pos[i];
      @(posedge sys_clk);
      stim <= 0;
      wait_irq();
      chk(irq, 1'b1);
      axi_rd(`OFS_STAT, d, r);
      chk(d, 32'h1 << i);
      axi_wr(`OFS_STAT, 32'h1 << i, r);
      axi_rd(`OFS_STAT, d, r);
      chk(d, `ZERO32);
      chk(irq, 1'b0);
    end
    axi_wr(`OFS_MASK, 32'h0, r);
    @(posedge sys_clk);
    stim <= 21'h1 << 11;
    @(posedge sys_clk);
    stim <= 0;
    repeat (4) @(posedge sys_clk);
    #1;
    chk(irq, 1'b0);
    axi_wr(`OFS_MASK, 32'h1, r);
    wait_irq();
    chk(irq, 1'b1);
    axi_wr(`OFS_STAT, 32'h1, r);
    repeat (2) @(posedge sys_clk);
    #1;
    chk(irq, 1'b0);
    $display("interrupt test done");
    summarize();
  end
endmodule
`default_nettype wire
